//--- shared/emp_pkg.sv
// How it works
// R01 - The memory holds 65536 bytes, picked by sixteen address lines, seen on eight data pins.
// R02 - The memory has seven modes, set by both enables, line 9 and line 0.
// R03 - To read, both enables go low and the memory drives the addressed byte.
// R04 - On a shared bus every memory not being read has one enable held high.
// R05 - With chip enable low and output enable high the memory releases its data pins.
// R06 - With chip enable high the memory is in standby and its data pins float.
// R07 - Programming needs the program supply on output enable, chip enable low, data driven in.
// R08 - Bytes may be programmed singly, in blocks or in any address order.
// R09 - Signature mode needs line 9 at the high voltage, both enables low, line 0 picks the code.
// R10 - With the program supply on and chip enable high nothing is programmed, data pins float.
// R11 - Address and data are stable before each 100 us chip enable pulse, then a verify follows.
// R12 - At most ten pulses go to one byte, and a byte failing after the tenth is reported failed.
// R13 - Address and enables hold through a read, data is sampled after the access delay.
// R14 - In signature mode all address lines other than 0 and 9 are held low.
`default_nettype none

package emp_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_WIDTH = 16;
   localparam int DATA_WIDTH = 8;
   localparam int CNT_WIDTH = 13;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_PULSE_US = 100;
   localparam int PROG_PULSE_CYCLES = (PROG_PULSE_US * 1000) / CLK_PERIOD_NS;
   localparam int ACCESS_NS = 250;
   localparam int ACCESS_CYCLES = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYCLES = 2;
   localparam logic [3:0] MAX_PULSES = 4'hA;

   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 16'h0000;
   localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;
   localparam int ID_LINE = 9;

   // Command codes from user
   typedef enum logic [1:0] {
      EMP_CMD_READ = 2'h0,
      EMP_CMD_PROGRAM = 2'h1,
      EMP_CMD_SIGNATURE = 2'h2
   } emp_cmd_type;

   // Sequencer states, Gray from idle through verify on the program path
   typedef enum logic [2:0] {
      EMP_IDLE = 3'h0,
      EMP_SETUP = 3'h1,
      EMP_PULSE = 3'h3,
      EMP_RECOVER = 3'h2,
      EMP_VERIFY = 3'h6,
      EMP_READ = 3'h7,
      EMP_DONE = 3'h5
   } emp_state_type;

endpackage : emp_pkg

`default_nettype wire

//--- shared/emp_timer_if.sv
`default_nettype none

// Link between sequencer and its cycle timer
interface emp_timer_if;
   import emp_pkg::*;
   logic load;
   logic [CNT_WIDTH-1:0] count;
   logic expired;
   modport ctrl (output load, output count, input expired);
   modport timer (input load, input count, output expired);
endinterface : emp_timer_if

`default_nettype wire

//--- hdl/emp_timer.sv
`default_nettype none

module emp_timer
   import emp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // Sequencer side
   emp_timer_if.timer tmr
);

   logic [CNT_WIDTH-1:0] remaining;

   // Down counter, expired once it reaches zero
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         remaining <= '0;
      end else if (tmr.load) begin
         remaining <= tmr.count;
      end else if (remaining != '0) begin
         remaining <= remaining - 1'b1;
      end
   end

   // Load is built from expired, so expired must not look back at load
   assign tmr.expired = (remaining == '0);

endmodule : emp_timer

`default_nettype wire

//--- hdl/emp_host.sv
`default_nettype none

module emp_host
   import emp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // User command port
   input wire logic cmd_valid_in,
   input wire logic [1:0] cmd_op_in,
   input wire logic [ADDR_WIDTH-1:0] cmd_addr_in,
   input wire logic [DATA_WIDTH-1:0] cmd_data_in,
   output logic cmd_ready_out,
   output logic done_out,
   output logic fail_out,
   output logic [DATA_WIDTH-1:0] rd_data_out,
   // Memory pins
   output logic [ADDR_WIDTH-1:0] address_lines_out,
   output logic chip_en_n_out,
   output logic out_en_n_out,
   output logic vpp_on_out,
   output logic id_high_voltage_out,
   input wire logic [DATA_WIDTH-1:0] data_pins_in,
   output logic [DATA_WIDTH-1:0] data_pins_out,
   output logic data_pins_oe_out
);

   // ****************************************
   // Declarations
   // ****************************************
   emp_state_type state;
   emp_cmd_type op;
   logic [DATA_WIDTH-1:0] wr_byte;
   logic [3:0] pulses;
   logic [DATA_WIDTH-1:0] data_meta;
   logic [DATA_WIDTH-1:0] data_sync;
   emp_timer_if tif ();

   emp_timer u_timer (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .tmr(tif.timer)
   );

   // ****************************************
   // Pin input synchroniser
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         data_meta <= DATA_RESET;
         data_sync <= DATA_RESET;
      end else begin
         data_meta <= data_pins_in;
         data_sync <= data_meta;
      end
   end

   // ****************************************
   // Timer loads
   // ****************************************
   always_comb begin
      tif.load = 1'b0;
      tif.count = '0;
      unique case (state)
         EMP_IDLE: begin
            tif.load = cmd_valid_in;
            tif.count = CNT_WIDTH'(SETUP_CYCLES);
         end
         EMP_SETUP: begin
            tif.load = tif.expired;
            // A state lasts count plus one cycles, so one less gives the exact pulse
            tif.count = (op == EMP_CMD_PROGRAM) ? CNT_WIDTH'(PROG_PULSE_CYCLES - 1) // R11
                                                : CNT_WIDTH'(ACCESS_CYCLES + 2); // R13
         end
         EMP_PULSE: begin
            tif.load = tif.expired;
            tif.count = CNT_WIDTH'(SETUP_CYCLES);
         end
         EMP_RECOVER: begin
            tif.load = tif.expired;
            tif.count = CNT_WIDTH'(ACCESS_CYCLES + 2); // R11
         end
         EMP_VERIFY: begin
            tif.load = tif.expired && (data_sync != wr_byte) && (pulses != MAX_PULSES);
            tif.count = CNT_WIDTH'(SETUP_CYCLES);
         end
         EMP_READ, EMP_DONE: begin
            tif.load = 1'b0;
         end
         default: tif.load = 1'b0;
      endcase
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= EMP_IDLE;
         op <= EMP_CMD_READ;
         wr_byte <= DATA_RESET;
         pulses <= 4'h0;
      end else begin
         unique case (state)
            EMP_IDLE: if (cmd_valid_in) begin
               op <= emp_cmd_type'(cmd_op_in);
               wr_byte <= cmd_data_in;
               pulses <= 4'h0;
               state <= EMP_SETUP; // R08
            end
            EMP_SETUP: if (tif.expired) begin
               state <= (op == EMP_CMD_PROGRAM) ? EMP_PULSE : EMP_READ;
            end
            EMP_PULSE: if (tif.expired) begin
               pulses <= pulses + 4'h1; // R12
               state <= EMP_RECOVER;
            end
            EMP_RECOVER: if (tif.expired) begin
               state <= EMP_VERIFY; // R11
            end
            EMP_VERIFY: if (tif.expired) begin
               if (data_sync == wr_byte || pulses == MAX_PULSES) begin
                  state <= EMP_DONE; // R12
               end else begin
                  // Retry through setup so chip enable falls again for a real pulse
                  state <= EMP_SETUP; // R12
               end
            end
            EMP_READ: if (tif.expired) begin
               state <= EMP_DONE;
            end
            EMP_DONE: state <= EMP_IDLE;
            default: state <= EMP_IDLE;
         endcase
      end
   end

   // ****************************************
   // Pin drive, all registered
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         address_lines_out <= ADDR_RESET;
         chip_en_n_out <= 1'b1; // R04
         out_en_n_out <= 1'b1;
         vpp_on_out <= 1'b0;
         id_high_voltage_out <= 1'b0;
         data_pins_out <= DATA_RESET;
         data_pins_oe_out <= 1'b0;
      end else if (state == EMP_IDLE && cmd_valid_in) begin
         // Address set up with chip idle so nothing is touched early
         if (emp_cmd_type'(cmd_op_in) == EMP_CMD_SIGNATURE) begin
            address_lines_out <= ADDR_RESET; // R14
            address_lines_out[ID_LINE] <= 1'b1;
            address_lines_out[0] <= cmd_addr_in[0]; // R09
            id_high_voltage_out <= 1'b1; // R09
         end else begin
            address_lines_out <= cmd_addr_in; // R01
         end
         if (emp_cmd_type'(cmd_op_in) == EMP_CMD_PROGRAM) begin
            vpp_on_out <= 1'b1; // R07
            data_pins_out <= cmd_data_in;
            data_pins_oe_out <= 1'b1; // R11
         end
      end else begin
         unique case (state)
            EMP_SETUP: if (tif.expired) begin
               chip_en_n_out <= 1'b0; // R03
               out_en_n_out <= (op == EMP_CMD_PROGRAM); // R07
            end
            EMP_PULSE: if (tif.expired) begin
               chip_en_n_out <= 1'b1; // R10
               vpp_on_out <= 1'b0;
               data_pins_oe_out <= 1'b0;
            end
            EMP_RECOVER: if (tif.expired) begin
               chip_en_n_out <= 1'b0; // R11
               out_en_n_out <= 1'b0;
            end
            EMP_VERIFY: if (tif.expired) begin
               chip_en_n_out <= 1'b1;
               out_en_n_out <= 1'b1;
               if (data_sync != wr_byte && pulses != MAX_PULSES) begin
                  vpp_on_out <= 1'b1;
                  data_pins_oe_out <= 1'b1;
               end
            end
            EMP_READ: if (tif.expired) begin
               chip_en_n_out <= 1'b1; // R13
               out_en_n_out <= 1'b1;
            end
            EMP_DONE: begin
               id_high_voltage_out <= 1'b0;
               address_lines_out <= ADDR_RESET;
            end
            default: chip_en_n_out <= 1'b1;
         endcase
      end
   end

   // ****************************************
   // User answers
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cmd_ready_out <= 1'b0;
         done_out <= 1'b0;
         fail_out <= 1'b0;
         rd_data_out <= DATA_RESET;
      end else begin
         cmd_ready_out <= (state == EMP_IDLE) && !cmd_valid_in || (state == EMP_DONE);
         done_out <= 1'b0;
         if ((state == EMP_READ) && tif.expired) begin
            rd_data_out <= data_sync; // R13
            done_out <= 1'b1;
            fail_out <= 1'b0;
         end
         if ((state == EMP_VERIFY) && tif.expired
             && (data_sync == wr_byte || pulses == MAX_PULSES)) begin
            rd_data_out <= data_sync;
            done_out <= 1'b1;
            fail_out <= (data_sync != wr_byte); // R12
         end
      end
   end

endmodule : emp_host

`default_nettype wire

//--- bench/emp_host_asserts.sv
`default_nettype none
// ****
// Pin protocol checks
// ****
module emp_host_asserts
   import emp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // Status
   input wire logic cmd_ready_out,
   input wire logic done_out,
   input wire logic fail_out,
   // Memory pins
   input wire logic [ADDR_WIDTH-1:0] address_lines_out,
   input wire logic chip_en_n_out,
   input wire logic out_en_n_out,
   input wire logic vpp_on_out,
   input wire logic id_high_voltage_out,
   input wire logic [DATA_WIDTH-1:0] data_pins_out,
   input wire logic data_pins_oe_out
);
   logic [12:0] pulse_len;
   logic [3:0] pulse_num;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   // Cycles in the running program pulse
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) pulse_len <= 13'h0000;
      else if (!chip_en_n_out && vpp_on_out) pulse_len <= pulse_len + 13'h0001;
      else pulse_len <= 13'h0000;
   end
   // Pulses per command, cleared by done
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) pulse_num <= 4'h0;
      else if (done_out) pulse_num <= 4'h0;
      else if (!chip_en_n_out && vpp_on_out && pulse_len == 13'h0000)
         pulse_num <= pulse_num + 4'h1;
   end
   a_pulse_length: assert property ($rose(chip_en_n_out) && $past(vpp_on_out)
      |-> pulse_len == PROG_PULSE_CYCLES) else $error("program pulse length wrong");
   a_pulse_limit: assert property (pulse_num <= MAX_PULSES)
      else $error("too many program pulses");
   a_fail_ten: assert property (done_out && fail_out |-> pulse_num == MAX_PULSES)
      else $error("fail before tenth pulse");
   a_drive_prog_only: assert property (data_pins_oe_out |-> vpp_on_out && out_en_n_out)
      else $error("data driven outside programming");
   a_prog_drives: assert property (vpp_on_out && !chip_en_n_out |-> data_pins_oe_out)
      else $error("program byte not driven");
   a_pulse_setup: assert property ($fell(chip_en_n_out) && vpp_on_out
      |-> $stable(address_lines_out) && $stable(data_pins_out)) else $error("setup not stable");
   a_access_stable: assert property (!chip_en_n_out && !$past(chip_en_n_out)
      |-> $stable(address_lines_out) && $stable(out_en_n_out)) else $error("access unstable");
   a_verify_follows: assert property ($rose(chip_en_n_out) && $past(vpp_on_out)
      |-> ##[1:8] (!chip_en_n_out && !out_en_n_out && !vpp_on_out)) else $error("no verify");
   a_sig_addr_low: assert property (id_high_voltage_out
      |-> (address_lines_out & 16'hFDFE) == 16'h0000 && !vpp_on_out) else $error("sig addr");
   a_done_release: assert property (done_out |=> chip_en_n_out && !vpp_on_out)
      else $error("pins held after done");
   // Main scenarios seen
   c_read: cover property (done_out && !fail_out);
   c_fail: cover property (done_out && fail_out);
   c_sig: cover property (id_high_voltage_out && !chip_en_n_out);
endmodule : emp_host_asserts

bind emp_host emp_host_asserts u_asserts (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
   .cmd_ready_out(cmd_ready_out), .done_out(done_out), .fail_out(fail_out),
   .address_lines_out(address_lines_out), .chip_en_n_out(chip_en_n_out),
   .out_en_n_out(out_en_n_out), .vpp_on_out(vpp_on_out),
   .id_high_voltage_out(id_high_voltage_out), .data_pins_out(data_pins_out),
   .data_pins_oe_out(data_pins_oe_out));
`default_nettype wire

//--- bench/emp_mem_model.sv
`default_nettype none
// ****
// Behavioural memory on the far side
// ****
module emp_mem_model
   import emp_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'hC3 // Arbitrary value
)(
   // Pins from the controller
   input wire logic [15:0] addr_in,
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic vpp_in,
   input wire logic id_in,
   input wire logic [7:0] host_d_in,
   input wire logic host_oe_in,
   // Fault and speed controls
   input wire logic [15:0] stuck_in,
   input wire logic slow_in,
   // Resolved data bus
   output logic [7:0] bus_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [65536];
   logic [7:0] q = 8'hFF;
   logic [7:0] last = 8'h00;
   logic drv;
   // Erased array is all ones
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // Outputs only in read, verify and signature
   assign drv = !ce_n_in && !oe_n_in && !vpp_in;
   // Access delay, prompt or slow; the array stays out of the list, so only address, enable, vpp, id and speed changes reread
   always @(addr_in, id_in, ce_n_in, oe_n_in, vpp_in, slow_in) begin
      q <= #(slow_in ? 240 : 30) (id_in ? (addr_in[0] ? PART_CODE : MAKER_CODE)
                                        : mem[addr_in]);
   end
   // Released bus shows the inverse of its last value, contention shows unknown
   assign bus_out = (host_oe_in && drv) ? 8'hXX : host_oe_in ? host_d_in : drv ? q : ~last;
   always @(bus_out) if (drv || host_oe_in) last = bus_out;
   // Program on pulse start, any order; stuck address never takes
   always @(negedge ce_n_in) if (vpp_in && host_oe_in && addr_in !== stuck_in)
      mem[addr_in] = mem[addr_in] & host_d_in;
endmodule : emp_mem_model
`default_nettype wire

//--- bench/testbench.sv
`default_nettype none
// ****
// Controller bench
// ****
module testbench
   import emp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
   localparam logic [7:0] PART = 8'hC3; // Arbitrary value
   logic clk_sys_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic cmd_valid = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] cmd_data = 8'h00;
   logic [15:0] stuck = 16'h0000;
   logic slow = 1'b0;
   logic cmd_ready, done, fail, ce_n, oe_n, vpp, idv, d_oe;
   logic [7:0] rd_data, d_out, bus;
   logic [15:0] addr;
   int mismatches = 0, checked = 0, pulses = 0, cycles = 0;
   emp_host DUT (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid),
      .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
      .cmd_ready_out(cmd_ready), .done_out(done), .fail_out(fail), .rd_data_out(rd_data),
      .address_lines_out(addr), .chip_en_n_out(ce_n), .out_en_n_out(oe_n), .vpp_on_out(vpp),
      .id_high_voltage_out(idv), .data_pins_in(bus), .data_pins_out(d_out),
      .data_pins_oe_out(d_oe));
   emp_mem_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_mem (.addr_in(addr), .ce_n_in(ce_n),
      .oe_n_in(oe_n), .vpp_in(vpp), .id_in(idv), .host_d_in(d_out), .host_oe_in(d_oe),
      .stuck_in(stuck), .slow_in(slow), .bus_out(bus));
   // 40 MHz clock
   initial forever #12.5 clk_sys_in = ~clk_sys_in;
   // Pulses seen at the pins
   always @(negedge ce_n) if (vpp) pulses++;
   // Hang guard, well above about 52400 cycles of work
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 70000) begin
         mismatches++;
         complete_run();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One command, valid for a single cycle, then wait for done
   task automatic do_cmd(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk_sys_in);
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clk_sys_in);
         n++;
      end
      @(posedge clk_sys_in);
      pulses = 0;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      @(posedge clk_sys_in);
      cmd_valid <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 45000) begin
         @(negedge clk_sys_in);
         n++;
      end
      // A command that never finishes counts as a mismatch here
      check(done, 16'h0001);
   endtask : do_cmd
   // Erased byte through a slow part
   task automatic t_read_erased;
      slow <= 1'b1;
      do_cmd(2'h0, 16'hFFFF, 8'h00);
      check(rd_data, 8'hFF);
      slow <= 1'b0;
   endtask : t_read_erased
   // Scattered programs, read back in reverse order
   task automatic t_program;
      logic [15:0] al [3] = '{16'h1234, 16'h0001, 16'hFFFE};
      logic [7:0] dl [3] = '{8'h5A, 8'hA5, 8'h00};
      for (int i = 0; i < 3; i++) begin
         do_cmd(2'h1, al[i], dl[i]);
         check({fail, pulses[3:0]}, 16'h0001);
      end
      for (int i = 2; i >= 0; i--) begin
         do_cmd(2'h0, al[i], 8'h00);
         check(rd_data, dl[i]);
      end
   endtask : t_program
   // Both identification bytes
   task automatic t_signature;
      for (int i = 0; i < 2; i++) begin
         do_cmd(2'h2, 16'(i), 8'h00);
         check(rd_data, (i == 1) ? PART : MAKER);
      end
   endtask : t_signature
   // Byte that never takes: ten pulses, then failure
   task automatic t_fail;
      stuck <= 16'h0100;
      do_cmd(2'h1, 16'h0100, 8'h0F);
      check({fail, pulses[3:0]}, 16'h001A);
      do_cmd(2'h0, 16'h0100, 8'h00);
      check({fail, rd_data}, 16'h00FF);
   endtask : t_fail
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys_in);
      check({ce_n, vpp, idv, d_oe}, 16'h0008);
      reset_n_in <= 1'b1;
      t_read_erased();
      t_program();
      t_signature();
      t_fail();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
